// ---- verilog/scwd_top.sv ----
// System control and watchdog registers on the board I/O bus.
// Assumes a synchronous 8-bit I/O bus, synchronous pins, and a 200 MHz clock.
`timescale 1ns/1ps
`include "scwd_map.svh"
module scwd_top #(
  parameter int unsigned TICK_CYCLES = `SCWD_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire scwd_pkg::scwd_bus_t bus,
  output logic [7:0] rdata,
  input wire logic config_switch,
  output logic stop_n,
  output logic red_led_on,
  output logic watchdog_enable,
  output logic watchdog_timed_out_n,
  output logic hw_reset_req,
  output logic nmi_req
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] system_control;
  logic [7:0] watchdog_configuration;
  logic watchdog_enable_bit;
  logic [7:0] setup_low;
  logic [11:0] ticks;
  logic [11:0] limit;
  logic tick;
  logic kick_restart;
  logic timeout;
  logic sw_reset;
  scwd_pkg::scwd_state_t state;
  scwd_pkg::scwd_state_t next_state;

  function automatic logic hit(input scwd_pkg::scwd_bus_t b, input logic [15:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  // Period in 100 ms ticks
  function automatic logic [11:0] period_ticks(input logic [3:0] code, input logic sw);
    if (code == 4'h0)
      period_ticks = sw ? 12'(`SCWD_SHORT_MS / `SCWD_TICK_MS) : 12'(`SCWD_LONG_MS / `SCWD_TICK_MS);
    else if (code <= 4'h7)
      period_ticks = 12'((`SCWD_BASE_S * 1000 / `SCWD_TICK_MS) << (code - 4'h1));
    else
      period_ticks = 12'((`SCWD_BASE_S * 1000 / `SCWD_TICK_MS) << 6);
  endfunction

  assign sw_reset = hit(bus, `SCWD_ADDR_OPTION) && bus.wdata == `SCWD_HW_RESET_CODE;
  assign kick_restart = hit(bus, `SCWD_ADDR_SYSTEM_CONTROL)
    && (bus.wdata[`SCWD_BIT_KICK] != system_control[`SCWD_BIT_KICK]);

  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      system_control <= `SCWD_CTRL_RESET;
    else if (hit(bus, `SCWD_ADDR_SYSTEM_CONTROL))
    begin
      system_control[`SCWD_BIT_TRIG_N] <= bus.wdata[`SCWD_BIT_TRIG_N];
      system_control[`SCWD_BIT_KICK] <= bus.wdata[`SCWD_BIT_KICK];
      system_control[`SCWD_BIT_ACTION] <= bus.wdata[`SCWD_BIT_ACTION];
      system_control[`SCWD_BIT_STOP] <= bus.wdata[`SCWD_BIT_STOP];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      watchdog_configuration <= `SCWD_WCFG_RESET;
    else if (hit(bus, `SCWD_ADDR_WATCHDOG_CONFIG))
    begin
      watchdog_configuration[`SCWD_BIT_LOCK] <= bus.wdata[`SCWD_BIT_LOCK];
      watchdog_configuration[3:0] <= bus.wdata[3:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      setup_low <= 8'h07;
    else if (hit(bus, `SCWD_ADDR_SETUP))
      setup_low <= {1'b0, bus.wdata[6:0]} & 8'he7;
  end

  // Enable may be cleared only while unlocked or while the watchdog is not in SCWD_RUN
  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      watchdog_enable_bit <= 1'b0;
    else if (hit(bus, `SCWD_ADDR_SETUP))
    begin
      if (bus.wdata[`SCWD_BIT_ENABLE] || !watchdog_configuration[`SCWD_BIT_LOCK] || state != scwd_pkg::SCWD_RUN)
        watchdog_enable_bit <= bus.wdata[`SCWD_BIT_ENABLE];
    end
  end

  // ****************************************
  // Watchdog timer
  // ****************************************
  scwd_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock(clock),
    .rst(rst || sw_reset),
    .restart(kick_restart || !watchdog_enable_bit),
    .tick(tick)
  );

  assign limit = period_ticks(watchdog_configuration[3:0], config_switch);
  assign timeout = state == scwd_pkg::SCWD_RUN && tick && ticks + 12'h1 >= limit;

  always_ff @(posedge clock)
  begin
    if (rst || sw_reset || kick_restart || state != scwd_pkg::SCWD_RUN)
      ticks <= 12'h0;
    else if (tick)
      ticks <= ticks + 12'h1;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      scwd_pkg::SCWD_IDLE:
        if (watchdog_enable_bit)
          next_state = scwd_pkg::SCWD_RUN;
      scwd_pkg::SCWD_RUN:
        if (!watchdog_enable_bit)
          next_state = scwd_pkg::SCWD_IDLE;
        else if (timeout)
          next_state = scwd_pkg::SCWD_FIRED;
      scwd_pkg::SCWD_FIRED:
        if (!watchdog_enable_bit)
          next_state = scwd_pkg::SCWD_IDLE;
      default:
        next_state = scwd_pkg::SCWD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      state <= scwd_pkg::SCWD_IDLE;
    else
      state <= next_state;
  end

  // Timed-out flag is cleared by both the board reset and the option reset
  always_ff @(posedge clock)
  begin
    if (rst || sw_reset)
      watchdog_timed_out_n <= 1'b1;
    else if (timeout)
      watchdog_timed_out_n <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hw_reset_req <= 1'b0;
      nmi_req <= 1'b0;
    end
    else
    begin
      hw_reset_req <= sw_reset || (timeout && !system_control[`SCWD_BIT_ACTION]);
      nmi_req <= timeout && system_control[`SCWD_BIT_ACTION];
    end
  end

  // ****************************************
  // Pins and read data
  // ****************************************
  assign stop_n = !system_control[`SCWD_BIT_STOP];
  assign red_led_on = !stop_n;
  assign watchdog_enable = watchdog_enable_bit;

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      case (bus.addr)
        `SCWD_ADDR_SYSTEM_CONTROL:
          rdata <= {system_control[7:4], 1'b0, 1'b1, 1'b0, 1'b1};
        `SCWD_ADDR_FUNCTION_CODE:
          rdata <= `SCWD_FUNCTION_CODE;
        `SCWD_ADDR_WATCHDOG_CONFIG:
          rdata <= {watchdog_configuration[7], 3'h0, watchdog_configuration[3:0]};
        `SCWD_ADDR_SETUP:
          rdata <= {setup_low[7], watchdog_enable_bit, setup_low[5:0]};
        default:
          rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_led;
    @(posedge clock) disable iff (rst) red_led_on == !stop_n;
  endproperty
  a_led: assert property (p_led) else $error("led mismatch");

  property p_stop;
    @(posedge clock) disable iff (rst)
      hit(bus, `SCWD_ADDR_SYSTEM_CONTROL) && !sw_reset |=> stop_n == !$past(bus.wdata[4]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not written");

  property p_err;
    @(posedge clock) disable iff (rst)
      bus.rd && bus.addr == `SCWD_ADDR_SYSTEM_CONTROL |=> rdata[1] == 1'b0;
  endproperty
  a_err: assert property (p_err) else $error("error enable not zero");

  property p_fid;
    @(posedge clock) disable iff (rst)
      bus.rd && bus.addr == `SCWD_ADDR_FUNCTION_CODE |=> rdata == `SCWD_FUNCTION_CODE;
  endproperty
  a_fid: assert property (p_fid) else $error("function code wrong");

  property p_lock;
    @(posedge clock) disable iff (rst)
      state == scwd_pkg::SCWD_RUN && watchdog_configuration[7] && !sw_reset |=> watchdog_enable_bit;
  endproperty
  a_lock: assert property (p_lock) else $error("locked watchdog disabled");

  property p_kick;
    @(posedge clock) disable iff (rst) kick_restart && !sw_reset |=> ticks == 12'h0;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not restart");

  property p_nmi;
    @(posedge clock) disable iff (rst)
      timeout && system_control[5] |=> nmi_req && !hw_reset_req;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not raised");

  property p_swrst;
    @(posedge clock) disable iff (rst) sw_reset |=> hw_reset_req && watchdog_timed_out_n;
  endproperty
  a_swrst: assert property (p_swrst) else $error("option reset failed");

  property p_period;
    @(posedge clock) disable iff (rst)
      watchdog_configuration[3:0] != 4'h0 && $changed(config_switch) |-> $stable(limit);
  endproperty
  a_period: assert property (p_period) else $error("period followed switch");
endmodule // scwd_top

// ---- verilog/scwd_map.svh ----
// Register offsets, field positions, reset values and timing counts of the system control watchdog.
// Assumes an 8-bit I/O bus with 16-bit addresses and a 200 MHz clock.
`ifndef SCWD_MAP_SVH
`define SCWD_MAP_SVH
`define SCWD_ADDR_SYSTEM_CONTROL 16'h8201
`define SCWD_ADDR_FUNCTION_CODE 16'h8202
`define SCWD_ADDR_WATCHDOG_CONFIG 16'h8203
`define SCWD_ADDR_OPTION 16'h8204
`define SCWD_ADDR_SETUP 16'h8205
`define SCWD_CTRL_RESET 8'h05
`define SCWD_WCFG_RESET 8'h80
`define SCWD_BIT_TRIG_N 7
`define SCWD_BIT_KICK 6
`define SCWD_BIT_ACTION 5
`define SCWD_BIT_STOP 4
`define SCWD_BIT_TRGSEL 3
`define SCWD_BIT_FREEZE 2
`define SCWD_BIT_ERR_EN_N 1
`define SCWD_BIT_ATT_EN_N 0
`define SCWD_BIT_LOCK 7
`define SCWD_BIT_ENABLE 6
`define SCWD_FUNCTION_CODE 8'h3c
`define SCWD_HW_RESET_CODE 8'ha5
`define SCWD_CLOCK_HZ 200000000
`define SCWD_TICK_MS 100
`define SCWD_TICK_CYCLES ((`SCWD_CLOCK_HZ / 1000) * `SCWD_TICK_MS)
`define SCWD_SHORT_MS 100
`define SCWD_LONG_MS 1000
`define SCWD_BASE_S 4
`endif

// ---- verilog/scwd_pkg.sv ----
// Types of the system control watchdog.
// Assumes nothing beyond the map header.
package scwd_pkg;
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scwd_bus_t;
  typedef enum logic [1:0]
  {
    SCWD_IDLE = 2'b00,
    SCWD_RUN = 2'b01,
    SCWD_FIRED = 2'b10
  } scwd_state_t;
endpackage

// ---- verilog/scwd_tick.sv ----
// Tick divider: one-cycle enable every tick period.
// Assumes the map header and one 200 MHz clock.
`timescale 1ns/1ps
`include "scwd_map.svh"
module scwd_tick #(
  parameter int unsigned TICK_CYCLES = `SCWD_TICK_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  logic [31:0] count;
  always_ff @(posedge clock)
  begin
    if (rst || restart || count == TICK_CYCLES - 1)
      count <= 32'h0;
    else
      count <= count + 32'h1;
  end
  assign tick = (count == TICK_CYCLES - 1) && !restart;
endmodule // scwd_tick

// ---- test/scwd_top_bench.sv ----
// Self-checking bench for the system control watchdog registers and timer.
// Assumes scwd_top with a short tick, driven on the falling clock edge.
`timescale 1ns/1ps
`include "scwd_map.svh"
module scwd_top_bench;
  localparam int TK = 10;
  logic clock = 1'b0;
  logic rst = 1'b1;
  scwd_pkg::scwd_bus_t bus = '0;
  logic config_switch = 1'b0;
  logic [7:0] rdata;
  logic stop_n, red_led_on, watchdog_enable, watchdog_timed_out_n, hw_reset_req, nmi_req;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h58b2;
  logic [7:0] d, x, ctrl_m;
  int code_q[$] = '{0, 0, 1, 1, 3};
  int sw_q[$] = '{1, 0, 0, 1, 0};
  int ticks_q[$] = '{1, 10, 40, 40, 160};

  scwd_top #(.TICK_CYCLES(TK)) i_dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .config_switch(config_switch), .stop_n(stop_n), .red_led_on(red_led_on),
    .watchdog_enable(watchdog_enable), .watchdog_timed_out_n(watchdog_timed_out_n),
    .hw_reset_req(hw_reset_req), .nmi_req(nmi_req));

  always #2.5 clock = ~clock;

  // ****************
  // Tasks
  // ****************
  task end_sim;
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      bad_count++;
      end_sim();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clock);
    bus.addr = a;
    bus.wdata = v;
    bus.wr = 1'b1;
    @(negedge clock);
    bus.wr = 1'b0;
    if (a == `SCWD_ADDR_SYSTEM_CONTROL)
      ctrl_m = {v[7:4], 4'h5};
  endtask

  task rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clock);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge clock);
    bus.rd = 1'b0;
    @(negedge clock);
    v = rdata;
  endtask

  task rst_dut;
    @(negedge clock);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    ctrl_m = `SCWD_CTRL_RESET;
  endtask

  task hold(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(negedge clock);
      if (watchdog_timed_out_n !== 1'b1)
        ok = 1'b0;
    end
    check({7'h0, ok}, 8'h01);
  endtask

  task fire(input int p, input logic act);
    int n, hw, nm;
    n = 0;
    hw = 0;
    nm = 0;
    while (watchdog_timed_out_n !== 1'b0 && n < p + 3 * TK)
    begin
      @(negedge clock);
      n++;
    end
    check({7'h0, n >= p - 1 && n <= p + 1}, 8'h01);
    repeat (3)
    begin
      hw += (hw_reset_req === 1'b1);
      nm += (nmi_req === 1'b1);
      @(negedge clock);
    end
    check(8'(hw), act ? 8'h00 : 8'h01);
    check(8'(nm), act ? 8'h01 : 8'h00);
  endtask

  // Enable by read-modify-write of the setup register
  task enable_wd;
    logic [7:0] s;
    rd(`SCWD_ADDR_SETUP, s);
    check(s, 8'h07);
    wr(`SCWD_ADDR_SETUP, s | 8'h40);
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    rst_dut();
    rd(`SCWD_ADDR_SYSTEM_CONTROL, d);
    check(d, ctrl_m);
    check({6'h0, stop_n, red_led_on}, 8'h02);
    rd(`SCWD_ADDR_WATCHDOG_CONFIG, d);
    check(d, `SCWD_WCFG_RESET);
    // Startup and bootloader hold stop asserted, then release it
    wr(`SCWD_ADDR_SYSTEM_CONTROL, 8'h15);
    repeat (4) @(negedge clock);
    check({6'h0, stop_n, red_led_on}, 8'h01);
    wr(`SCWD_ADDR_SYSTEM_CONTROL, 8'h05);
    check({6'h0, stop_n, red_led_on}, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      x = rnd();
      wr(`SCWD_ADDR_SYSTEM_CONTROL, x);
      check({7'h0, stop_n}, {7'h0, ~x[4]});
      check({7'h0, red_led_on}, {7'h0, x[4]});
      rd(`SCWD_ADDR_SYSTEM_CONTROL, d);
      check(d, ctrl_m);
      wr(`SCWD_ADDR_FUNCTION_CODE, 8'h00);
      rd(`SCWD_ADDR_FUNCTION_CODE, d);
      check(d, `SCWD_FUNCTION_CODE);
      wr(`SCWD_ADDR_WATCHDOG_CONFIG, x & 8'h87);
      rd(`SCWD_ADDR_WATCHDOG_CONFIG, d);
      check(d, x & 8'h87);
    end
    // Period per code and switch, action alternating
    foreach (code_q[i])
    begin
      rst_dut();
      config_switch = sw_q[i][0];
      wr(`SCWD_ADDR_WATCHDOG_CONFIG, 8'(code_q[i]));
      wr(`SCWD_ADDR_SYSTEM_CONTROL, i[0] ? 8'h25 : 8'h05);
      enable_wd();
      if (code_q[i] != 0)
        config_switch = ~config_switch;
      fire(ticks_q[i] * TK, i[0]);
    end
    // Option write after a timeout
    wr(`SCWD_ADDR_OPTION, `SCWD_HW_RESET_CODE);
    x = 8'h0;
    repeat (4)
    begin
      x = x | {7'h0, hw_reset_req === 1'b1};
      @(negedge clock);
    end
    check(x, 8'h01);
    check({7'h0, watchdog_timed_out_n}, 8'h01);
    rd(`SCWD_ADDR_SYSTEM_CONTROL, d);
    check(d, `SCWD_CTRL_RESET);
    // Kick toggles restart the count
    rst_dut();
    config_switch = 1'b0;
    wr(`SCWD_ADDR_WATCHDOG_CONFIG, 8'h00);
    enable_wd();
    for (int k = 0; k < 2; k++)
    begin
      hold(60);
      wr(`SCWD_ADDR_SYSTEM_CONTROL, k ? 8'h05 : 8'h45);
    end
    hold(80);
    fire(20, 1'b0);
    // Lock refuses disabling a running watchdog
    rst_dut();
    wr(`SCWD_ADDR_WATCHDOG_CONFIG, 8'h87);
    enable_wd();
    wr(`SCWD_ADDR_SETUP, 8'h00);
    check({7'h0, watchdog_enable}, 8'h01);
    rd(`SCWD_ADDR_WATCHDOG_CONFIG, d);
    check(d, 8'h87);
    wr(`SCWD_ADDR_WATCHDOG_CONFIG, 8'h07);
    wr(`SCWD_ADDR_SETUP, 8'h00);
    check({7'h0, watchdog_enable}, 8'h00);
    end_sim();
  end
endmodule // scwd_top_bench
